// ===== rtl/converter_status_defines.vh
// constants for the converter status register bank
// Overview of operation
// - driver bits 15..13 show active panel drivers
// - one-hot running field indexed by function code
// - running field clears on done, halt, reset
// - scan mode keeps bit 0/1 on done without touch
// - function status at address 15, reserved zero
// - status register at address 8, reset 0004h
// - ready bits 15..11, reset flag bit 7
// - ready bit set on store, cleared after read
// - reset flag zero after reset until read
// - powerdown state follows control on touch/start
`ifndef CONVERTER_STATUS_DEFINES_VH
`define CONVERTER_STATUS_DEFINES_VH
`define ADDR_STATUS_FLAGS 4'h8
`define ADDR_FUNC_RUN 4'hf
`define STATUS_FLAGS_RST 16'h0004
`define FUNC_RUN_RST 16'h0000
`define DRV_X_BIT 13
`define DRV_Y_BIT 14
`define DRV_YX_BIT 15
`define READY_LSB 11
`define RESET_FLAG_BIT 7
`define PD_STATE_BIT 2
`define NUM_FUNCS 9
`define NUM_MEAS 5
`endif

// ===== rtl/converter_status_regs.v
// status registers for function run state and measurement readiness
`include "converter_status_defines.vh"

module converter_status_regs #(
  parameter NUM_FUNCS = `NUM_FUNCS,
  parameter NUM_MEAS = `NUM_MEAS
) (
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  input wire i_soft_reset_bit,
  // sequencer observation
  input wire i_func_start,
  input wire [3:0] i_function_code,
  input wire i_func_done,
  input wire i_halt_request_bit,
  input wire i_scan_mode_select,
  input wire i_pen_touch,
  input wire i_drv_x_on,
  input wire i_drv_y_on,
  input wire i_drv_yx_on,
  input wire i_powerdown_ctrl,
  // data register events, one bit per x, y, z1, z2, aux
  input wire [NUM_MEAS-1:0] i_result_store,
  input wire [NUM_MEAS-1:0] i_result_read,
  // host register port
  input wire i_reg_rd,
  input wire i_reg_wr,
  input wire [3:0] i_reg_addr,
  output reg [15:0] o_reg_rdata
);

  reg [2:0] drv_reg;
  wire [2:0] drv_next;
  wire [2:0] drv_in;
  wire drv_clear;
  reg [NUM_FUNCS-1:0] function_run_bits_reg;
  reg [NUM_FUNCS-1:0] function_run_bits_next;
  reg [NUM_MEAS-1:0] result_ready_reg;
  wire [NUM_MEAS-1:0] result_ready_next;
  reg reset_seen_reg;
  reg reset_seen_next;
  reg powerdown_state_reg;
  reg powerdown_state_next;
  reg [15:0] rdata_next;
  wire any_reset;
  wire stop_evt;
  wire status_rd;
  wire [15:0] func_run_word;
  wire [15:0] status_word;

  assign any_reset = i_rst | i_soft_reset_bit;
  assign stop_evt = i_func_done | i_halt_request_bit;

  // --------------------------------------------------------------
  // running function and driver status
  // --------------------------------------------------------------
  always @* begin
    function_run_bits_next = function_run_bits_reg;
    if (i_func_start && (i_function_code < NUM_FUNCS)) begin
      function_run_bits_next = {NUM_FUNCS{1'b0}};
      function_run_bits_next[i_function_code] = 1'b1;
    end else if (i_halt_request_bit) begin
      function_run_bits_next = {NUM_FUNCS{1'b0}};
    end else if (i_func_done) begin
      // scan mode without a touch keeps bits 0/1 so the next touch restarts at once
      if (i_scan_mode_select && !i_pen_touch) begin
        function_run_bits_next = function_run_bits_reg & {{(NUM_FUNCS-2){1'b0}}, 2'b11};
      end else begin
        function_run_bits_next = {NUM_FUNCS{1'b0}};
      end
    end
  end

  // --------------------------------------------------------------
  // driver status
  // --------------------------------------------------------------
  // a start in the same cycle as done or halt keeps the drivers live
  assign drv_in = {i_drv_yx_on, i_drv_y_on, i_drv_x_on};
  assign drv_clear = stop_evt & ~i_func_start;

  genvar d;
  generate
    for (d = 0; d < 3; d = d + 1) begin : g_drv
      assign drv_next[d] = drv_clear ? 1'b0 : drv_in[d];
    end
  endgenerate

  always @(posedge i_mclk) begin
    if (any_reset) begin
      function_run_bits_reg <= {NUM_FUNCS{1'b0}};
      drv_reg <= 3'h0;
    end else begin
      function_run_bits_reg <= function_run_bits_next;
      drv_reg <= drv_next;
    end
  end

  // --------------------------------------------------------------
  // status flags
  // --------------------------------------------------------------
  // store beats read-out in one cycle so fresh data is never hidden
  genvar g;
  generate
    for (g = 0; g < NUM_MEAS; g = g + 1) begin : g_ready
      assign result_ready_next[g] = i_result_store[g] ? 1'b1 :
                                    (i_result_read[g] ? 1'b0 : result_ready_reg[g]);
    end
  endgenerate

  always @(posedge i_mclk) begin
    if (any_reset) begin
      result_ready_reg <= {NUM_MEAS{1'b0}};
    end else begin
      result_ready_reg <= result_ready_next;
    end
  end

  // flag bit is low (reset seen) until the first status read after reset
  assign status_rd = i_reg_rd & (i_reg_addr == `ADDR_STATUS_FLAGS);

  always @* begin
    reset_seen_next = reset_seen_reg;
    if (status_rd) begin
      reset_seen_next = 1'b0;
    end
  end

  always @(posedge i_mclk) begin
    if (any_reset) begin
      reset_seen_reg <= 1'b1;
    end else begin
      reset_seen_reg <= reset_seen_next;
    end
  end

  // the state bit lags the control bit; it samples only at touch or start,
  // so a host polling right after a control write may still see the old state
  always @* begin
    powerdown_state_next = powerdown_state_reg;
    if (i_pen_touch || i_func_start) begin
      powerdown_state_next = i_powerdown_ctrl;
    end
  end

  always @(posedge i_mclk) begin
    if (any_reset) begin
      powerdown_state_reg <= 1'b1;
    end else begin
      powerdown_state_reg <= powerdown_state_next;
    end
  end

  // --------------------------------------------------------------
  // read mux; writes have no path into any flag
  // --------------------------------------------------------------
  assign func_run_word = {drv_reg, 4'h0, function_run_bits_reg};
  assign status_word = {result_ready_reg, 3'h0, ~reset_seen_reg, 4'h0,
                        powerdown_state_reg, 2'h0};

  always @* begin
    rdata_next = o_reg_rdata;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `ADDR_STATUS_FLAGS: rdata_next = status_word;
        `ADDR_FUNC_RUN: rdata_next = func_run_word;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_reg_rdata <= 16'h0000;
    end else begin
      o_reg_rdata <= rdata_next;
    end
  end

endmodule // converter_status_regs

// ===== tb/conv_status_sva.sv
// checker for the status register read port
module conv_chk (
  input wire i_mclk,
  input wire i_rst,
  input wire i_soft_reset_bit,
  input wire i_halt_request_bit,
  input wire i_func_start,
  input wire i_pen_touch,
  input wire i_reg_rd,
  input wire i_reg_wr,
  input wire [3:0] i_reg_addr,
  input wire [15:0] o_reg_rdata
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_rd8; i_reg_rd && i_reg_addr == 4'h8; endsequence
  sequence s_rd15; i_reg_rd && i_reg_addr == 4'hf; endsequence
  sequence s_halt;
    i_halt_request_bit && !i_func_start ##1 !i_func_start && !i_pen_touch
      ##1 s_rd15 and !i_func_start;
  endsequence
  property p_unmap;
    i_reg_rd && i_reg_addr != 4'h8 && i_reg_addr != 4'hf |=> o_reg_rdata == 16'h0000;
  endproperty
  property p_res8; s_rd8 |=> (o_reg_rdata & 16'h077b) == 16'h0000; endproperty
  property p_res15;
    s_rd15 |=> (o_reg_rdata & 16'h1e00) == 16'h0000 && $onehot0(o_reg_rdata[8:0]);
  endproperty
  property p_wr; i_reg_wr && !i_reg_rd |=> $stable(o_reg_rdata); endproperty
  property p_hold; !i_reg_rd [*2] |-> $stable(o_reg_rdata); endproperty
  property p_sr; i_soft_reset_bit ##1 !i_reg_rd ##1 s_rd8 |=> !o_reg_rdata[7]; endproperty
  property p_flag1;
    (s_rd8 and !i_soft_reset_bit) ##1 !i_soft_reset_bit [*3] ##0 s_rd8 |=> o_reg_rdata[7];
  endproperty
  property p_halt; s_halt |=> o_reg_rdata[8:0] == 9'h000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_res8: assert property (p_res8) else $error("status reserved bits set");
  a_res15: assert property (p_res15) else $error("function word malformed");
  a_wr: assert property (p_wr) else $error("write changed read data");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_sr: assert property (p_sr) else $error("flag not low after reset");
  a_flag1: assert property (p_flag1) else $error("flag not high");
  a_halt: assert property (p_halt) else $error("run bits kept after halt");
endmodule // conv_chk
bind converter_status_regs conv_chk u_chk (.i_mclk, .i_rst, .i_soft_reset_bit,
  .i_halt_request_bit, .i_func_start, .i_pen_touch, .i_reg_rd, .i_reg_wr,
  .i_reg_addr, .o_reg_rdata);

// ===== tb/host_model.sv
// host model issuing single register accesses
module host_model (
  input wire i_mclk,
  output logic o_rd = 1'b0,
  output logic o_wr = 1'b0,
  output logic [3:0] o_addr = 4'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle strobe; the extra edge lets the registered answer settle
  task acc(input logic w, input logic [3:0] a);
    @(negedge i_mclk);
    o_rd <= !w;
    o_wr <= w;
    o_addr <= a;
    @(negedge i_mclk);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_addr <= ~a;
    @(negedge i_mclk);
  endtask
endmodule // host_model

// ===== tb/tb_top.sv
// testbench for the converter status registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 0, i_rst = 1, scan = 0, pdc = 1, pen = 0, rd, wr;
  logic [3:0] ev = 0, code = 0, ad;
  logic [2:0] drv = 0;
  logic [4:0] st = 0, rr = 0, m;
  logic [15:0] q;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  always #2.5 i_mclk = ~i_mclk;
  converter_status_regs u_dut (.i_mclk, .i_rst, .i_soft_reset_bit(ev[0]),
    .i_func_start(ev[3]), .i_function_code(code), .i_func_done(ev[2]),
    .i_halt_request_bit(ev[1]), .i_scan_mode_select(scan), .i_pen_touch(pen),
    .i_drv_x_on(drv[0]), .i_drv_y_on(drv[1]), .i_drv_yx_on(drv[2]),
    .i_powerdown_ctrl(pdc), .i_result_store(st), .i_result_read(rr),
    .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_addr(ad), .o_reg_rdata(q));
  host_model u_host (.i_mclk, .o_rd(rd), .o_wr(wr), .o_addr(ad));
  function [15:0] fw(input [2:0] d, input [3:0] c); return {d, 4'h0, 9'h1 << c}; endfunction
  task chk(input [15:0] s, input [15:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  task rdc(input [3:0] a, input [15:0] e); u_host.acc(1'b0, a); chk(q, e); endtask
  task pulse(input [3:0] e);
    @(negedge i_mclk) ev = e;
    @(negedge i_mclk) ev = 4'h0;
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(32'h3b9181f8));
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk) i_rst = 0;
    rdc(4'h8, 16'h0004);
    rdc(4'h8, 16'h0084);
    rdc(4'hf, 16'h0000);
    u_host.acc(1'b1, 4'h8);
    rdc(4'h8, 16'h0084);
    rdc(4'h3, 16'h0000);
    $display("reset test done");
    repeat (8) begin
      m = 5'($urandom_range(1, 31));
      @(negedge i_mclk) st = m;
      @(negedge i_mclk) st = 5'h00;
      rdc(4'h8, {m, 11'h084});
      @(negedge i_mclk) rr = m;
      @(negedge i_mclk) rr = 5'h00;
      rdc(4'h8, 16'h0084);
    end
    $display("ready test done");
    for (int c = 0; c < 9; c++) begin
      drv = 3'($urandom);
      code = 4'(c);
      pulse(4'h8);
      rdc(4'hf, fw(drv, code));
      drv = 3'h0;
      pulse(4'h4);
      rdc(4'hf, 16'h0000);
    end
    $display("function test done");
    scan = 1;
    code = 4'h1;
    pulse(4'h8);
    pulse(4'h4);
    rdc(4'hf, 16'h0002);
    pulse(4'h2);
    rdc(4'hf, 16'h0000);
    code = 4'h0;
    pulse(4'h8);
    @(negedge i_mclk) pen = 1;
    pulse(4'h4);
    pen = 0;
    rdc(4'hf, 16'h0000);
    pdc = 0;
    pulse(4'h8);
    rdc(4'h8, 16'h0080);
    pdc = 1;
    @(negedge i_mclk) pen = 1;
    @(negedge i_mclk) pen = 0;
    rdc(4'h8, 16'h0084);
    pulse(4'h1);
    rdc(4'h8, 16'h0004);
    rdc(4'hf, 16'h0000);
    $display("scan test done");
    finish_test;
  end
endmodule // tb_top
